// >>> include/msc_pkg.sv
/*
  Constants shared by the motor speed control register bank: I2C address,
  register offsets, field positions, unlock key, bus state encoding and the
  power-up contents of the nonvolatile configuration store.
  Assumes it is compiled before every design file that uses it.
*/
`default_nettype none

package msc_pkg;

  // 7-bit I2C slave address of the device
  localparam logic [6:0] I2C_ADDR = 7'h52;

  // Register offsets (byte addresses on the I2C register pointer)
  localparam logic [7:0] ADDR_SPEED_LO = 8'h00;
  localparam logic [7:0] ADDR_SPEED_HI = 8'h01;
  localparam logic [7:0] ADDR_UNLOCK = 8'h02;
  localparam logic [7:0] ADDR_NV_CTRL = 8'h03;
  localparam logic [7:0] ADDR_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_CFG_FIRST = 8'h20;
  localparam logic [7:0] ADDR_CFG_LAST = 8'h2B;

  localparam int CFG_COUNT = 12;
  localparam int SPEED_W = 9;
  localparam int CFG_IDX_W = 4;

  // Key that arms one nonvolatile program operation
  localparam logic [7:0] PROGRAM_KEY = 8'hB6;

  // Field positions
  localparam int BIT_HOST_SEL = 7;
  localparam int BIT_SPEED_MSB = 0;
  localparam int BIT_INHIBIT = 7;
  localparam int BIT_CFG_WE = 6;
  localparam int BIT_RELOAD = 5;
  localparam int BIT_PROGRAM = 4;

  // Bits in a byte, as counted by the bus engine
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] PTR_STEP = 8'h01;

  // Bus engine states, Gray coded along the usual path
  typedef enum logic [2:0] {
    MSC_IDLE = 3'b000,
    MSC_ADDR = 3'b001,
    MSC_AACK = 3'b011,
    MSC_RX = 3'b010,
    MSC_RACK = 3'b110,
    MSC_TX = 3'b111,
    MSC_TACK = 3'b101
  } msc_i2c_state_t;

  // Power-up contents of the store, element 0 is offset 0x20
  localparam logic [CFG_COUNT-1:0][7:0] NV_DEFAULT = {
    8'h0C, 8'hAD, 8'hB7, 8'h69, 8'hFC, 8'h7A,
    8'hE4, 8'h98, 8'h00, 8'h2A, 8'h4E, 8'h4A
  };

endpackage

`default_nettype wire

// >>> hw/msc_cfg_bank.sv
/*
  Twelve configuration registers with their nonvolatile backing store.
  Assumes the register bank supplies decoded write strobes, the write enable
  bit and one-cycle reload and program pulses on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module msc_cfg_bank #(
  parameter int COUNT = msc_pkg::CFG_COUNT
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Write side
  input wire logic i_wr_en,
  input wire logic [msc_pkg::CFG_IDX_W-1:0] i_wr_idx,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_allow,
  // Store operations
  input wire logic i_reload,
  input wire logic i_program,
  // Read side
  input wire logic [msc_pkg::CFG_IDX_W-1:0] i_rd_idx,
  output logic [7:0] o_rd_data
);

  typedef struct packed {
    logic [COUNT-1:0][7:0] cfg;
    logic [COUNT-1:0][7:0] nv;
  } msc_bank_t;

  msc_bank_t q;
  msc_bank_t n;

  always_comb begin
    n = q;
    // Program takes the old register contents even if reload fires too
    if (i_program) begin
      n.nv = q.cfg;
    end
    if (i_reload) begin
      n.cfg = q.nv;
    end else if (i_wr_en && i_wr_allow && (int'(i_wr_idx) < COUNT)) begin
      n.cfg[i_wr_idx] = i_wr_data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      q <= {msc_pkg::NV_DEFAULT, msc_pkg::NV_DEFAULT};
    end else begin
      q <= n;
    end
  end

  assign o_rd_data = (int'(i_rd_idx) < COUNT) ? q.cfg[i_rd_idx] : 8'h00;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  a_cfg_write_lock: assert property ((i_wr_en && !i_wr_allow && !i_reload) |=> $stable(q.cfg))
    else $error("configuration changed while writes were locked");

  a_reload_copy: assert property (i_reload |=> (q.cfg == $past(q.nv)))
    else $error("reload did not copy the store into the registers");

  a_program_copy: assert property (i_program |=> (q.nv == $past(q.cfg)))
    else $error("program did not copy the registers into the store");

endmodule

`default_nettype wire

// >>> hw/msc_regs.sv
/*
  Control and status register bank of a sensorless motor driver, reached by
  an I2C slave engine with an auto-incrementing register pointer.
  Assumes SCL and SDA arrive synchronous to i_clk_sys and far slower than it;
  the open-drain SDA wire is resolved outside from o_sda_out and o_sda_oe.
*/
`timescale 1ns/1ps
`default_nettype none

module msc_regs #(
  parameter int SPEED_W = msc_pkg::SPEED_W
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // I2C pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Motor core side
  input wire logic [SPEED_W-1:0] i_ext_speed,
  input wire logic i_standby_req,
  input wire logic i_thermal,
  input wire logic i_current_fault,
  input wire logic i_rotor_stall,
  // Results
  output logic [SPEED_W-1:0] o_speed_command_value,
  output logic o_standby
);

  typedef struct packed {
    msc_pkg::msc_i2c_state_t st;
    logic scl_prev;
    logic sda_prev;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic rw;
    logic ptr_phase;
    logic mack;
    logic [7:0] ptr;
    logic sda_oe;
    logic sda_out;
    logic host_speed_select;
    logic msb_pend;
    logic [SPEED_W-1:0] cmd;
    logic [7:0] program_unlock_key;
    logic standby_inhibit;
    logic cfg_we;
    logic nv_reload;
    logic nv_program;
    logic thermal_flag;
    logic standby;
    logic current_fault_flag;
    logic rotor_stall_flag;
    logic [SPEED_W-1:0] speed_out;
  } msc_state_t;

  msc_state_t q;
  msc_state_t n;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic wr_en;
  logic rd_take;
  logic [7:0] rd_byte;
  logic [7:0] cfg_rd;
  logic [msc_pkg::CFG_IDX_W-1:0] wr_idx;
  logic [msc_pkg::CFG_IDX_W-1:0] rd_idx;

  function automatic logic is_cfg(input logic [7:0] a);
    return (a >= msc_pkg::ADDR_CFG_FIRST) && (a <= msc_pkg::ADDR_CFG_LAST);
  endfunction

  function automatic logic [msc_pkg::CFG_IDX_W-1:0] cfg_idx(input logic [7:0] a);
    logic [7:0] off;
    off = a - msc_pkg::ADDR_CFG_FIRST;
    return off[msc_pkg::CFG_IDX_W-1:0];
  endfunction

  // Read view of every register; holes and unused bits answer zero
  function automatic logic [7:0] read_view(input logic [7:0] a, input msc_state_t s, input logic [7:0] cfg);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      msc_pkg::ADDR_SPEED_LO: v = s.cmd[7:0];
      msc_pkg::ADDR_SPEED_HI: begin
        v[msc_pkg::BIT_HOST_SEL] = s.host_speed_select;
        v[msc_pkg::BIT_SPEED_MSB] = s.msb_pend;
      end
      msc_pkg::ADDR_UNLOCK: v = s.program_unlock_key;
      msc_pkg::ADDR_NV_CTRL: begin
        // Reload and program are commands and read back as zero
        v[msc_pkg::BIT_INHIBIT] = s.standby_inhibit;
        v[msc_pkg::BIT_CFG_WE] = s.cfg_we;
      end
      msc_pkg::ADDR_FLAGS: begin
        v = {s.thermal_flag, s.standby, s.current_fault_flag, s.rotor_stall_flag, 4'h0};
      end
      default: begin
        if (is_cfg(a)) begin
          v = cfg;
        end
      end
    endcase
    return v;
  endfunction

  assign scl_rise = i_scl && !q.scl_prev;
  assign scl_fall = !i_scl && q.scl_prev;
  assign bus_start = i_scl && q.scl_prev && q.sda_prev && !i_sda;
  assign bus_stop = i_scl && q.scl_prev && !q.sda_prev && i_sda;
  assign rd_idx = cfg_idx(q.ptr);
  assign wr_idx = cfg_idx(q.ptr);
  assign rd_byte = read_view(q.ptr, q, cfg_rd);

  always_comb begin
    n = q;
    wr_en = 1'b0;
    rd_take = 1'b0;
    n.scl_prev = i_scl;
    n.sda_prev = i_sda;
    n.nv_reload = 1'b0;
    n.nv_program = 1'b0;

    // Bus engine; a stop or start ends any transfer in progress
    if (bus_stop) begin
      n.st = msc_pkg::MSC_IDLE;
      n.sda_oe = 1'b0;
    end else if (bus_start) begin
      n.st = msc_pkg::MSC_ADDR;
      n.cnt = 4'h0;
      n.sda_oe = 1'b0;
    end else begin
      case (q.st)
        msc_pkg::MSC_IDLE: begin
          n.sda_oe = 1'b0;
        end
        msc_pkg::MSC_ADDR: begin
          if (scl_rise) begin
            n.sh = {q.sh[6:0], i_sda};
            n.cnt = q.cnt + 4'h1;
          end else if (scl_fall && (q.cnt == msc_pkg::BITS_PER_BYTE)) begin
            if (q.sh[7:1] == msc_pkg::I2C_ADDR) begin
              n.rw = q.sh[0];
              n.sda_oe = 1'b1;
              n.st = msc_pkg::MSC_AACK;
            end else begin
              n.st = msc_pkg::MSC_IDLE;
            end
          end
        end
        msc_pkg::MSC_AACK: begin
          if (scl_fall) begin
            n.cnt = 4'h0;
            if (q.rw) begin
              rd_take = 1'b1;
              n.st = msc_pkg::MSC_TX;
            end else begin
              n.sda_oe = 1'b0;
              n.ptr_phase = 1'b1;
              n.st = msc_pkg::MSC_RX;
            end
          end
        end
        msc_pkg::MSC_RX: begin
          if (scl_rise) begin
            n.sh = {q.sh[6:0], i_sda};
            n.cnt = q.cnt + 4'h1;
          end else if (scl_fall && (q.cnt == msc_pkg::BITS_PER_BYTE)) begin
            n.sda_oe = 1'b1;
            n.st = msc_pkg::MSC_RACK;
            if (q.ptr_phase) begin
              n.ptr = q.sh;
            end else begin
              wr_en = 1'b1;
              n.ptr = q.ptr + msc_pkg::PTR_STEP;
            end
          end
        end
        msc_pkg::MSC_RACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.cnt = 4'h0;
            n.ptr_phase = 1'b0;
            n.st = msc_pkg::MSC_RX;
          end
        end
        msc_pkg::MSC_TX: begin
          if (scl_rise) begin
            n.cnt = q.cnt + 4'h1;
          end else if (scl_fall) begin
            if (q.cnt == msc_pkg::BITS_PER_BYTE) begin
              n.sda_oe = 1'b0;
              n.st = msc_pkg::MSC_TACK;
            end else begin
              n.tx = {q.tx[6:0], 1'b0};
              n.sda_oe = !q.tx[6];
            end
          end
        end
        msc_pkg::MSC_TACK: begin
          if (scl_rise) begin
            n.mack = !i_sda;
          end else if (scl_fall) begin
            n.cnt = 4'h0;
            if (q.mack) begin
              rd_take = 1'b1;
              n.st = msc_pkg::MSC_TX;
            end else begin
              n.st = msc_pkg::MSC_IDLE;
            end
          end
        end
        default: begin
          n.st = msc_pkg::MSC_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end

    // Loading a byte for transmit is the read, with its side effects
    if (rd_take) begin
      n.tx = rd_byte;
      n.sda_oe = !rd_byte[7];
      n.ptr = q.ptr + msc_pkg::PTR_STEP;
    end

    // Register writes
    if (wr_en) begin
      if (q.ptr != msc_pkg::ADDR_UNLOCK) begin
        n.program_unlock_key = 8'h00;
      end
      case (q.ptr)
        msc_pkg::ADDR_SPEED_LO: begin
          // Top bit comes from the pending copy, so a lone top-bit write never shows a torn value
          n.cmd = {q.msb_pend, q.sh};
        end
        msc_pkg::ADDR_SPEED_HI: begin
          n.host_speed_select = q.sh[msc_pkg::BIT_HOST_SEL];
          n.msb_pend = q.sh[msc_pkg::BIT_SPEED_MSB];
        end
        msc_pkg::ADDR_UNLOCK: begin
          n.program_unlock_key = q.sh;
        end
        msc_pkg::ADDR_NV_CTRL: begin
          n.standby_inhibit = q.sh[msc_pkg::BIT_INHIBIT];
          n.cfg_we = q.sh[msc_pkg::BIT_CFG_WE];
          n.nv_reload = q.sh[msc_pkg::BIT_RELOAD];
          n.nv_program = q.sh[msc_pkg::BIT_PROGRAM] && (q.program_unlock_key == msc_pkg::PROGRAM_KEY);
        end
        default: begin
        end
      endcase
    end

    // Status and core-facing results
    n.thermal_flag = i_thermal;
    n.rotor_stall_flag = i_rotor_stall;
    n.standby = i_standby_req && !q.standby_inhibit;
    // A fault arriving in the cycle of the clearing read still sets the flag
    n.current_fault_flag = i_current_fault || (q.current_fault_flag &&
      !(rd_take && (q.ptr == msc_pkg::ADDR_FLAGS)));
    n.speed_out = q.host_speed_select ? q.cmd : i_ext_speed;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      q <= '0;
      // Idle bus levels, so the first edge after reset sees no false SCL rise
      q.scl_prev <= 1'b1;
      q.sda_prev <= 1'b1;
    end else begin
      q <= n;
    end
  end

  msc_cfg_bank #(
    .COUNT(msc_pkg::CFG_COUNT)
  ) u_cfg (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_wr_en(wr_en && is_cfg(q.ptr)),
    .i_wr_idx(wr_idx),
    .i_wr_data(q.sh),
    .i_wr_allow(q.cfg_we),
    .i_reload(q.nv_reload),
    .i_program(q.nv_program),
    .i_rd_idx(rd_idx),
    .o_rd_data(cfg_rd)
  );

  assign o_sda_out = q.sda_out;
  assign o_sda_oe = q.sda_oe;
  assign o_speed_command_value = q.speed_out;
  assign o_standby = q.standby;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  a_low_byte_store: assert property ((wr_en && q.ptr == msc_pkg::ADDR_SPEED_LO) |=>
    (q.cmd[7:0] == $past(q.sh)))
    else $error("low speed byte not stored");

  a_speed_snapshot: assert property ((wr_en && q.ptr == msc_pkg::ADDR_SPEED_LO) |=>
    (q.cmd[SPEED_W-1] == $past(q.msb_pend)))
    else $error("top speed bit not taken at the low byte write");

  a_msb_waits: assert property ((wr_en && q.ptr == msc_pkg::ADDR_SPEED_HI) |=> $stable(q.cmd))
    else $error("speed command changed on a top-bit write");

  a_host_select: assert property (q.host_speed_select |=> (o_speed_command_value == $past(q.cmd)))
    else $error("speed output ignores the host command");

  a_key_clear: assert property ((wr_en && q.ptr != msc_pkg::ADDR_UNLOCK) |=>
    (q.program_unlock_key == 8'h00))
    else $error("unlock key survived a later write");

  a_program_armed: assert property (q.nv_program |->
    ($past(q.program_unlock_key) == msc_pkg::PROGRAM_KEY && $past(wr_en)))
    else $error("program started without the unlock key");

  a_standby_inhibit: assert property (q.standby_inhibit |=> !o_standby)
    else $error("standby entered while inhibited");

  a_fault_sticky: assert property (i_current_fault |=> q.current_fault_flag)
    else $error("overcurrent flag missed an event");

  a_fault_hold: assert property ((q.current_fault_flag && !(rd_take && q.ptr == msc_pkg::ADDR_FLAGS)) |=>
    q.current_fault_flag)
    else $error("overcurrent flag dropped without a status read");

  a_fault_clear: assert property ((rd_take && q.ptr == msc_pkg::ADDR_FLAGS && !i_current_fault) |=>
    !q.current_fault_flag)
    else $error("status read left the overcurrent flag set");

  a_addr_mismatch: assert property ((q.st == msc_pkg::MSC_ADDR && scl_fall && !bus_start && !bus_stop &&
    q.cnt == msc_pkg::BITS_PER_BYTE && q.sh[7:1] != msc_pkg::I2C_ADDR) |=> ##[0:1] !o_sda_oe)
    else $error("acknowledged a foreign address");

endmodule

`default_nettype wire

// >>> tb/msc_i2c_master.sv
/*
  Behavioural I2C bus master that stands in for the host controller.
  Assumes the bench resolves SDA from o_sda_low, the slave enable and a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none

module msc_i2c_master (
  // Clock
  input wire logic i_clk_sys,
  // Bus
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask

  // Also serves as repeated START: SDA is released while SCL is still low
  task automatic start();
    o_sda_low = 1'b0;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    o_sda_low = 1'b1;
    tick(4);
    o_scl = 1'b0;
    tick(2);
  endtask

  task automatic stop();
    o_sda_low = 1'b1;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    o_sda_low = 1'b0;
    tick(4);
  endtask

  task automatic bit_out(input logic b);
    o_sda_low = ~b;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    o_scl = 1'b0;
    tick(2);
  endtask

  task automatic bit_in(output logic b);
    o_sda_low = 1'b0;
    tick(2);
    o_scl = 1'b1;
    tick(3);
    b = i_sda;
    tick(1);
    o_scl = 1'b0;
    tick(2);
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    ack = ~a;
  endtask

  // A high last ends the read with a NACK
  task automatic recv(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(last);
  endtask
endmodule

`default_nettype wire

// >>> tb/msc_regs_bench.sv
/*
  Self-checking bench for the motor speed register bank: an integer model of the
  registers is compared with every read byte and output, and with each acknowledge except those of pointer bytes and of a read's first address byte.
  Assumes the master model in msc_i2c_master and an SDA pull-up.
*/
`timescale 1ns/1ps
`default_nettype none

module msc_regs_bench;
  logic clk, rst, standby_req, thermal, cur_fault, stall;
  logic [8:0] ext_speed;
  logic [8:0] speed_out;
  logic standby_out, sda_out, sda_oe, scl, sda_low;
  wire logic sda_w;
  int error_cnt, n_checks, cyc, seed, d;
  int m_cfg[12], m_store[12];
  int m_key, m_ctrl, m_hi, m_cmd, m_oc;

  assign sda_w = (sda_oe | sda_low) ? 1'b0 : 1'b1;

  msc_i2c_master m_u (.i_clk_sys(clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(sda_low));

  msc_regs dut_u (.i_clk_sys(clk), .i_reset(rst), .i_scl(scl), .i_sda(sda_w),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_ext_speed(ext_speed),
    .i_standby_req(standby_req), .i_thermal(thermal), .i_current_fault(cur_fault),
    .i_rotor_stall(stall), .o_speed_command_value(speed_out), .o_standby(standby_out));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Ceiling well above the roughly 20k cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk_val(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_ack(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic mdl_wr(input int p, input int v);
    int prog;
    int t;
    prog = (p == 3) && v[4] && (m_key == 'hB6);
    m_key = (p == 2) ? v : 0;
    if (p == 0) m_cmd = (m_hi & 1) * 256 + v;
    if (p == 1) m_hi = v & 'h81;
    if (p == 3) begin
      m_ctrl = v & 'hC0;
      for (int i = 0; i < 12; i++) begin
        t = m_cfg[i];
        if (v[5]) m_cfg[i] = m_store[i];
        if (prog) m_store[i] = t;
      end
    end
    if (p >= 'h20 && p <= 'h2B && m_ctrl[6]) m_cfg[p - 'h20] = v;
  endtask

  function automatic int mdl_rd(input int p);
    case (p)
      0: return m_cmd & 'hFF;
      1: return m_hi;
      2: return m_key;
      3: return m_ctrl;
      'h10: return {thermal, standby_req & ~m_ctrl[7], m_oc[0], stall, 4'h0};
      default: return (p >= 'h20 && p <= 'h2B) ? m_cfg[p - 'h20] : 0;
    endcase
  endfunction

  task automatic wr(input int p, input int n, input int d0, input int d1);
    logic a;
    m_u.start();
    m_u.send({msc_pkg::I2C_ADDR, 1'b0}, a);
    chk_ack("addr ack", 1'b1, a);
    m_u.send(8'(p), a);
    for (int i = 0; i < n; i++) begin
      m_u.send(8'(i ? d1 : d0), a);
      chk_ack("data ack", 1'b1, a);
      mdl_wr(p + i, i ? d1 : d0);
    end
    m_u.stop();
    repeat (3) @(negedge clk);
  endtask

  // Reads n bytes in one transfer; the master ACKs all but the last
  task automatic rd(input int p, input int n = 1);
    logic a;
    logic [7:0] v;
    m_u.start();
    m_u.send({msc_pkg::I2C_ADDR, 1'b0}, a);
    m_u.send(8'(p), a);
    m_u.start();
    m_u.send({msc_pkg::I2C_ADDR, 1'b1}, a);
    chk_ack("read addr ack", 1'b1, a);
    for (int i = 0; i < n; i++) begin
      m_u.recv(i == n - 1, v);
      chk_val("read byte", 9'(mdl_rd(p + i)), {1'b0, v});
      if (p + i == 'h10) m_oc = cur_fault;
    end
    m_u.stop();
  endtask

  task automatic chk_outs();
    repeat (2) @(negedge clk);
    chk_val("speed", m_hi[7] ? 9'(m_cmd) : ext_speed, speed_out);
    chk_val("standby", 9'(standby_req & ~m_ctrl[7]), {8'h00, standby_out});
    chk_ack("sda out", 1'b0, sda_out);
  endtask

  initial begin
    logic a;
    seed = 58713;
    rst = 1'b1;
    standby_req = 1'b0;
    thermal = 1'b0;
    cur_fault = 1'b0;
    stall = 1'b0;
    ext_speed = 9'h000;
    for (int i = 0; i < 12; i++) m_cfg[i] = msc_pkg::NV_DEFAULT[i];
    m_store = m_cfg;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    for (int p = 0; p < 'h30; p++) if (p < 6 || p == 'h10 || p >= 'h20) rd(p);
    $display("test reset contents done");
    ext_speed = 9'($random(seed));
    chk_outs();
    wr(1, 1, 'hFF, 0);
    chk_outs();
    d = $random(seed) & 'hFF;
    wr(0, 1, d, 0);
    chk_outs();
    rd(1);
    rd(0);
    wr(1, 1, 'h00, 0);
    chk_outs();
    $display("test speed command done");
    standby_req = 1'b1;
    chk_outs();
    rd('h10);
    wr(3, 1, 'h8F, 0);
    chk_outs();
    rd(3);
    rd('h10);
    $display("test standby done");
    wr('h20, 1, d ^ 'h5A, 0);
    rd('h20);
    wr(3, 1, 'h40, 0);
    wr('h21, 2, d, d ^ 'hA5);
    rd('h21);
    rd('h22);
    wr('h20, 1, 'h11, 0);
    wr(3, 1, 'h50, 0);
    wr(3, 1, 'h60, 0);
    rd('h20);
    rd('h21);
    wr(2, 1, 'hB6, 0);
    wr('h20, 1, 'h22, 0);
    rd(2);
    wr(3, 1, 'h50, 0);
    wr(3, 1, 'h60, 0);
    rd('h20);
    wr('h20, 1, 'h33, 0);
    wr(2, 2, 'hB6, 'h50);
    wr('h20, 1, 'h44, 0);
    wr(3, 1, 'h60, 0);
    rd('h20);
    wr('h2B, 1, 'h55, 0);
    wr(2, 1, 'hB6, 0);
    wr(3, 1, 'h50, 0);
    wr('h2B, 1, 'h66, 0);
    wr(3, 1, 'h60, 0);
    rd('h2B);
    rd('h20, 3);
    $display("test configuration store done");
    thermal = 1'b1;
    stall = 1'b1;
    cur_fault = 1'b1;
    m_oc = 1;
    repeat (3) @(negedge clk);
    cur_fault = 1'b0;
    repeat (3) @(negedge clk);
    rd('h10);
    rd('h10);
    thermal = 1'b0;
    stall = 1'b0;
    wr('h10, 1, 'hFF, 0);
    rd('h10);
    $display("test status flags done");
    m_u.start();
    m_u.send({msc_pkg::I2C_ADDR ^ 7'h01, 1'b0}, a);
    chk_ack("foreign addr ack", 1'b0, a);
    m_u.stop();
    rd(0);
    $display("test addressing done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
